// *** src/spf_top.v ***
// Purpose: serial port framer: async line to/from packet network
// Assumes: one clock, APB register access, network side is a byte stream
// Notes:   rx bytes gather into frames closed by idle gap or size limit
// Function
// - line rate 300..115200, default 19200
// - seven or eight data bits, eight default
// - none, odd or even parity bit
// - parity mismatch marks received character corrupted
// - configured stop bits end each character
// - idle gap over setting closes frame
// - frame closes at maximum receive size
// - flow control drops CTS at 2040 of 2048 buffer entries
// - second port may be differential multidrop
// - no protocol discards both directions
// - default datagram ports 8881 and 8882
// - bridge operation broadcasts every frame
// - source address follows outgoing interface
// - timeouts start at handoff to driver
`include "spf_regs.vh"
`default_nettype none

module spf_top #(
    parameter PORT_IDX = 0
) (
    input  wire        clk_sys,
    input  wire        rstn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    output reg         irq_q,
    input  wire        rxd,
    output wire        txd,
    input  wire        rts_n,
    output reg         cts_n_q,
    output wire        line_diff,
    output wire        drv_en,
    output wire        net_tx_valid,
    input  wire        net_tx_ready,
    output reg  [7:0]  net_tx_data,
    output reg         net_tx_last,
    output wire [15:0] net_tx_port,
    output wire        net_tx_bcast,
    output reg  [31:0] net_tx_src,
    input  wire        route_radio,
    input  wire        net_rx_valid,
    output wire        net_rx_ready,
    input  wire [7:0]  net_rx_data,
    input  wire        net_rx_last
);
    reg  [`SPF_CTRL_W-1:0] ctrl_q;
    reg  [10:0]            idle_q;
    reg  [10:0]            mrs_q;
    reg  [15:0]            port_q;
    reg  [31:0]            src_eth_q;
    reg  [31:0]            src_rad_q;
    reg  [15:0]            tmo_q;
    reg  [`SPF_EV_W-1:0]   stat_q;
    reg  [`SPF_EV_W-1:0]   ien_q;
    reg  [`SPF_EV_W-1:0]   ev;
    reg  [1:0]             rxs_q;
    reg  [1:0]             rtss_q;
    reg  [15:0]            bdiv_q;
    reg  [31:0]            bdiv_lim;
    reg                    tick_q;

    wire proto_on = ctrl_q[`SPF_C_PROTO];
    wire flow_on  = ctrl_q[`SPF_C_FLOW];
    wire data7    = ctrl_q[`SPF_C_DATA7];
    wire stop2    = ctrl_q[`SPF_C_STOP2];
    wire par_en   = ctrl_q[`SPF_C_PAR] != `SPF_PAR_NONE;
    wire par_odd  = ctrl_q[`SPF_C_PAR] == `SPF_PAR_ODD;

    // APB: zero wait states, read data captured in setup phase
    wire wr = psel & penable & pwrite;
    wire hit = paddr == `SPF_A_CTRL || paddr == `SPF_A_IDLE ||
               paddr == `SPF_A_MRS || paddr == `SPF_A_PORT ||
               paddr == `SPF_A_SRC_ETH || paddr == `SPF_A_SRC_RAD ||
               paddr == `SPF_A_TMO || paddr == `SPF_A_STAT ||
               paddr == `SPF_A_IEN || paddr == `SPF_A_ICLR ||
               paddr == `SPF_A_LEVEL;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // line rate divider for the 16x tick
    always @* begin
        case (ctrl_q[`SPF_C_RATE])
        4'h0: bdiv_lim = `SPF_CLK_HZ / (`SPF_OVS * `SPF_RATE0);
        4'h1: bdiv_lim = `SPF_CLK_HZ / (`SPF_OVS * `SPF_RATE1);
        4'h2: bdiv_lim = `SPF_CLK_HZ / (`SPF_OVS * `SPF_RATE2);
        4'h3: bdiv_lim = `SPF_CLK_HZ / (`SPF_OVS * `SPF_RATE3);
        4'h4: bdiv_lim = `SPF_CLK_HZ / (`SPF_OVS * `SPF_RATE4);
        4'h5: bdiv_lim = `SPF_CLK_HZ / (`SPF_OVS * `SPF_RATE5);
        4'h7: bdiv_lim = `SPF_CLK_HZ / (`SPF_OVS * `SPF_RATE7);
        4'h8: bdiv_lim = `SPF_CLK_HZ / (`SPF_OVS * `SPF_RATE8);
        4'h9: bdiv_lim = `SPF_CLK_HZ / (`SPF_OVS * `SPF_RATE9);
        default: bdiv_lim = `SPF_CLK_HZ / (`SPF_OVS * `SPF_RATE6);
        endcase
    end

    wire       rb_v;
    wire [7:0] rb_d;
    wire       rb_pe;
    wire       rb_fe;
    spf_uart_rx u_rx (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .rxd       (rxs_q[1]),
        .tick      (tick_q),
        .data7     (data7),
        .par_en    (par_en),
        .par_odd   (par_odd),
        .stop2     (stop2),
        .byte_v_q  (rb_v),
        .byte_q    (rb_d),
        .par_err_q (rb_pe),
        .frm_err_q (rb_fe)
    );

    // receive buffer: 9-bit entries, bit 8 marks frame end
    reg  [8:0]            mem [0:`SPF_FIFO_DEPTH-1];
    reg  [`SPF_FIFO_AW:0] wp_q;
    reg  [`SPF_FIFO_AW:0] rp_q;
    reg                   out_v_q;
    wire [`SPF_FIFO_AW:0] cnt  = wp_q - rp_q;
    wire                  full = cnt == `SPF_FIFO_DEPTH;
    wire                  empty = cnt == 12'h000;
    wire                  pop = ~empty & (~out_v_q | net_tx_ready);

    // frame assembly: newest byte waits in stage so a close can tag it
    reg  [7:0]  stg_q;
    reg         stg_v_q;
    reg  [10:0] flen_q;
    reg         mhit_q;
    reg  [7:0]  gtick_q;
    reg  [10:0] gchr_q;
    wire        good = rb_v & ~rb_pe & ~rb_fe;
    wire [10:0] flen_n = flen_q + 11'h001;
    wire [7:0]  ch_ticks = `SPF_OVS_8 * (8'h2 + (data7 ? 8'h7 : 8'h8) +
                           {7'h0, par_en} + {7'h0, stop2});
    wire        idle_hit = stg_v_q & ~mhit_q & (gchr_q > idle_q);
    wire        close = mhit_q | idle_hit;
    wire        wr_en = (good & proto_on & stg_v_q) | (~good & close);
    wire [8:0]  wr_d  = {~good & close, stg_q};

    // serial transmit
    reg  [11:0] tx_sh_q;
    reg  [3:0]  tx_n_q;
    reg  [3:0]  tx_ph_q;
    reg  [10:0] tx_vec;
    reg         tx_first_q;
    wire [7:0]  tdat = data7 ? {1'b0, net_rx_data[6:0]} : net_rx_data;
    wire        tpar = (^tdat) ^ par_odd ^ 1'b0;
    wire        tx_busy = tx_n_q != 4'h0;
    wire        rts_hold = flow_on & rtss_q[1];
    assign net_rx_ready = ~proto_on | (~tx_busy & ~rts_hold);
    wire        tx_take = net_rx_valid & net_rx_ready & proto_on;
    assign txd = tx_busy ? tx_sh_q[0] : 1'b1;

    always @* begin
        case ({data7, par_en})
        2'h0:    tx_vec = {3'h7, tdat};
        2'h1:    tx_vec = {2'h3, tpar, tdat};
        2'h2:    tx_vec = {4'hF, tdat[6:0]};
        default: tx_vec = {3'h7, tpar, tdat[6:0]};
        endcase
    end

    // response timeout in microseconds from handoff to the driver
    reg  [6:0]  us_q;
    reg  [15:0] tmo_cnt_q;
    reg         tmo_run_q;

    always @* begin
        ev = {`SPF_EV_W{1'b0}};
        ev[`SPF_EV_IDLE] = ~good & idle_hit;
        ev[`SPF_EV_MRS]  = ~good & mhit_q;
        ev[`SPF_EV_PAR]  = rb_v & rb_pe;
        ev[`SPF_EV_FRM]  = rb_v & rb_fe;
        ev[`SPF_EV_OVF]  = wr_en & full;
        ev[`SPF_EV_TMO]  = tmo_run_q & (tmo_cnt_q == tmo_q) & ~good;
    end

    assign net_tx_valid = out_v_q;
    assign net_tx_port  = port_q;
    assign net_tx_bcast = ctrl_q[`SPF_C_BRIDGE];
    assign line_diff    = (PORT_IDX != 0) & ctrl_q[`SPF_C_DIFF];
    assign drv_en       = ~line_diff | tx_busy;

    always @(posedge clk_sys) begin
        if (wr_en & ~full) mem[wp_q[`SPF_FIFO_AW-1:0]] <= wr_d;
        if (pop) begin
            net_tx_data <= mem[rp_q[`SPF_FIFO_AW-1:0]][7:0];
            net_tx_last <= mem[rp_q[`SPF_FIFO_AW-1:0]][8];
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_q     <= `SPF_CTRL_RST;
            idle_q     <= `SPF_IDLE_RST;
            mrs_q      <= `SPF_MRS_RST;
            port_q     <= 16'h0000;
            src_eth_q  <= 32'h0000_0000;
            src_rad_q  <= 32'h0000_0000;
            tmo_q      <= 16'h0000;
            stat_q     <= {`SPF_EV_W{1'b0}};
            ien_q      <= {`SPF_EV_W{1'b0}};
            prdata     <= 32'h0000_0000;
            irq_q      <= 1'b0;
            rxs_q      <= 2'h3;
            rtss_q     <= 2'h3;
            cts_n_q    <= 1'b0;
            bdiv_q     <= 16'h0000;
            tick_q     <= 1'b0;
            wp_q       <= 12'h000;
            rp_q       <= 12'h000;
            out_v_q    <= 1'b0;
            net_tx_src <= 32'h0000_0000;
            stg_q      <= 8'h00;
            stg_v_q    <= 1'b0;
            flen_q     <= 11'h000;
            mhit_q     <= 1'b0;
            gtick_q    <= 8'h00;
            gchr_q     <= 11'h000;
            tx_sh_q    <= 12'hFFF;
            tx_n_q     <= 4'h0;
            tx_ph_q    <= 4'h0;
            tx_first_q <= 1'b1;
            us_q       <= 7'h00;
            tmo_cnt_q  <= 16'h0000;
            tmo_run_q  <= 1'b0;
        end else begin
            // port number defaults per instance, loaded after reset
            if (port_q == 16'h0000)
                port_q <= (PORT_IDX != 0) ? `SPF_PORT_SECOND : `SPF_PORT_FIRST;
            rxs_q  <= {rxs_q[0], rxd};
            rtss_q <= {rtss_q[0], rts_n};
            tick_q <= 1'b0;
            bdiv_q <= bdiv_q + 16'h0001;
            if ({16'h0000, bdiv_q} >= bdiv_lim - 32'h0000_0001) begin
                bdiv_q <= 16'h0000;
                tick_q <= 1'b1;
            end

            // registers
            if (wr) begin
                if (paddr == `SPF_A_CTRL) begin
                    ctrl_q <= pwdata[`SPF_CTRL_W-1:0];
                end else if (paddr == `SPF_A_IDLE) begin
                    idle_q <= (pwdata[10:0] > `SPF_IDLE_MAX || |pwdata[31:11])
                              ? `SPF_IDLE_MAX : pwdata[10:0];
                end else if (paddr == `SPF_A_MRS) begin
                    mrs_q <= (pwdata[10:0] > `SPF_MRS_MAX || |pwdata[31:11])
                             ? `SPF_MRS_MAX : (pwdata[10:0] == 11'h000)
                             ? `SPF_MRS_MIN : pwdata[10:0];
                end else if (paddr == `SPF_A_PORT) begin
                    port_q <= pwdata[15:0];
                end else if (paddr == `SPF_A_SRC_ETH) begin
                    src_eth_q <= pwdata;
                end else if (paddr == `SPF_A_SRC_RAD) begin
                    src_rad_q <= pwdata;
                end else if (paddr == `SPF_A_TMO) begin
                    tmo_q <= pwdata[15:0];
                end else if (paddr == `SPF_A_IEN) begin
                    ien_q <= pwdata[`SPF_EV_W-1:0];
                end
            end
            // hardware set wins over a same-cycle software clear
            stat_q <= (stat_q & ~((wr && paddr == `SPF_A_ICLR) ?
                      pwdata[`SPF_EV_W-1:0] : {`SPF_EV_W{1'b0}})) | ev;
            irq_q  <= |(stat_q & ien_q);
            if (psel & ~penable) begin
                if (paddr == `SPF_A_CTRL)
                    prdata <= {20'h00000, ctrl_q};
                else if (paddr == `SPF_A_IDLE)
                    prdata <= {21'h000000, idle_q};
                else if (paddr == `SPF_A_MRS)
                    prdata <= {21'h000000, mrs_q};
                else if (paddr == `SPF_A_PORT)
                    prdata <= {16'h0000, port_q};
                else if (paddr == `SPF_A_SRC_ETH)
                    prdata <= src_eth_q;
                else if (paddr == `SPF_A_SRC_RAD)
                    prdata <= src_rad_q;
                else if (paddr == `SPF_A_TMO)
                    prdata <= {16'h0000, tmo_q};
                else if (paddr == `SPF_A_STAT)
                    prdata <= {26'h0000000, stat_q};
                else if (paddr == `SPF_A_IEN)
                    prdata <= {26'h0000000, ien_q};
                else if (paddr == `SPF_A_LEVEL)
                    prdata <= {16'h0000, tmo_run_q, tx_busy, cts_n_q,
                               1'b0, cnt};
                else
                    prdata <= 32'h0000_0000;
            end

            // a terminal that ignores CTS overflows and loses bytes
            cts_n_q <= flow_on & (cnt >= `SPF_FIFO_HI);

            // gap counter in character times, restarted per byte
            if (rb_v) begin
                gtick_q <= 8'h00;
                gchr_q  <= 11'h000;
            end else if (tick_q) begin
                gtick_q <= gtick_q + 8'h01;
                if (gtick_q + 8'h01 >= ch_ticks) begin
                    gtick_q <= 8'h00;
                    if (gchr_q != 11'h7FF) gchr_q <= gchr_q + 11'h001;
                end
            end

            // corrupted characters never enter a frame
            if (good & proto_on) begin
                stg_q   <= rb_d;
                stg_v_q <= 1'b1;
                flen_q  <= flen_n;
                if (flen_n >= mrs_q) mhit_q <= 1'b1;
            end else if (close) begin
                stg_v_q <= 1'b0;
                flen_q  <= 11'h000;
                mhit_q  <= 1'b0;
            end
            if (wr_en & ~full) wp_q <= wp_q + 12'h001;

            // network side: buffer read prefetch
            if (pop) begin
                rp_q    <= rp_q + 12'h001;
                out_v_q <= 1'b1;
            end else if (net_tx_ready) begin
                out_v_q <= 1'b0;
            end
            net_tx_src <= route_radio ? src_rad_q : src_eth_q;

            // transmit: start bit, data, parity, stop bits
            if (tx_take) begin
                tx_sh_q <= {tx_vec, 1'b0};
                tx_n_q  <= 4'h2 + (data7 ? 4'h7 : 4'h8) +
                           {3'h0, par_en} + {3'h0, stop2};
                tx_ph_q <= 4'h0;
            end else if (tx_busy & tick_q) begin
                tx_ph_q <= tx_ph_q + 4'h1;
                if (tx_ph_q == `SPF_OVS_END) begin
                    tx_sh_q <= {1'b1, tx_sh_q[11:1]};
                    tx_n_q  <= tx_n_q - 4'h1;
                end
            end

            // timeout counts from the first byte handed to the line
            if (tx_take) tx_first_q <= net_rx_last;
            us_q <= (us_q == `SPF_US_LAST) ? 7'h00 : us_q + 7'h01;
            if (tx_take & tx_first_q & (tmo_q != 16'h0000)) begin
                tmo_run_q <= 1'b1;
                tmo_cnt_q <= 16'h0000;
            end else if (good | ev[`SPF_EV_TMO]) begin
                tmo_run_q <= 1'b0;
            end else if (tmo_run_q && us_q == `SPF_US_LAST) begin
                tmo_cnt_q <= tmo_cnt_q + 16'h0001;
            end
        end
    end
endmodule // spf_top

`default_nettype wire

// *** pkg/spf_regs.vh ***
// Purpose: constants for the serial port framer (map, resets, timing)
// Assumes: 125 MHz system clock, 16x receive oversampling
// Notes:   register offsets are byte addresses on a 32-bit APB
`ifndef SPF_REGS_VH
`define SPF_REGS_VH

`define SPF_CLK_HZ      125000000
`define SPF_OVS         16
`define SPF_OVS_MID     4'h7
`define SPF_OVS_END     4'hF
`define SPF_OVS_8       8'h10
`define SPF_US_NS       1000
`define SPF_CLK_NS      8
`define SPF_US_CYC      (`SPF_US_NS / `SPF_CLK_NS)
`define SPF_US_LAST     7'h7C

// selectable line rates, index 0..9
`define SPF_RATE0       300
`define SPF_RATE1       600
`define SPF_RATE2       1200
`define SPF_RATE3       2400
`define SPF_RATE4       4800
`define SPF_RATE5       9600
`define SPF_RATE6       19200
`define SPF_RATE7       38400
`define SPF_RATE8       57600
`define SPF_RATE9       115200

// register byte offsets
`define SPF_A_CTRL      8'h00
`define SPF_A_IDLE      8'h04
`define SPF_A_MRS       8'h08
`define SPF_A_PORT      8'h0C
`define SPF_A_SRC_ETH   8'h10
`define SPF_A_SRC_RAD   8'h14
`define SPF_A_TMO       8'h18
`define SPF_A_STAT      8'h1C
`define SPF_A_IEN       8'h20
`define SPF_A_ICLR      8'h24
`define SPF_A_LEVEL     8'h28

// control fields
`define SPF_C_RATE      3:0
`define SPF_C_DATA7     4
`define SPF_C_PAR       6:5
`define SPF_C_STOP2     7
`define SPF_C_FLOW      8
`define SPF_C_PROTO     9
`define SPF_C_DIFF      10
`define SPF_C_BRIDGE    11
`define SPF_CTRL_W      12
`define SPF_CTRL_RST    12'h006
`define SPF_PAR_NONE    2'h0
`define SPF_PAR_ODD     2'h1
`define SPF_PAR_EVEN    2'h2

// frame limits
`define SPF_IDLE_RST    11'h005
`define SPF_IDLE_MAX    11'h7D0
`define SPF_MRS_RST     11'h640
`define SPF_MRS_MAX     11'h640
`define SPF_MRS_MIN     11'h001
`define SPF_PORT_FIRST  16'h22B1
`define SPF_PORT_SECOND 16'h22B2

// status bits
`define SPF_EV_W        6
`define SPF_EV_IDLE     0
`define SPF_EV_MRS      1
`define SPF_EV_PAR      2
`define SPF_EV_FRM      3
`define SPF_EV_OVF      4
`define SPF_EV_TMO      5

// receive buffer
`define SPF_FIFO_AW     11
`define SPF_FIFO_DEPTH  12'h800
`define SPF_FIFO_HI     12'h7F8

`endif

// *** src/spf_uart_rx.v ***
// Purpose: serial character receiver, 16x oversampled
// Assumes: rxd already synchronised, tick is one cycle per sixteenth bit
// Notes:   a start bit shorter than half a bit is dropped as a glitch
`include "spf_regs.vh"
`default_nettype none

module spf_uart_rx (
    input  wire       clk_sys,
    input  wire       rstn,
    input  wire       rxd,
    input  wire       tick,
    input  wire       data7,
    input  wire       par_en,
    input  wire       par_odd,
    input  wire       stop2,
    output reg        byte_v_q,
    output reg  [7:0] byte_q,
    output reg        par_err_q,
    output reg        frm_err_q
);
    localparam S_IDLE  = 3'h0;
    localparam S_START = 3'h1;
    localparam S_DATA  = 3'h2;
    localparam S_PAR   = 3'h3;
    localparam S_STOP  = 3'h4;

    reg [2:0] st_q;
    reg [3:0] ph_q;
    reg [3:0] n_q;
    reg [7:0] sh_q;
    reg       pe_q;
    wire [7:0] dat   = data7 ? {1'b0, sh_q[7:1]} : sh_q;
    wire [3:0] lastn = data7 ? 4'h6 : 4'h7;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q      <= S_IDLE;
            ph_q      <= 4'h0;
            n_q       <= 4'h0;
            sh_q      <= 8'h00;
            pe_q      <= 1'b0;
            byte_v_q  <= 1'b0;
            byte_q    <= 8'h00;
            par_err_q <= 1'b0;
            frm_err_q <= 1'b0;
        end else begin
            byte_v_q <= 1'b0;
            if (tick) begin
                ph_q <= ph_q + 4'h1;
                case (st_q)
                S_IDLE: begin
                    ph_q <= 4'h0;
                    if (!rxd) st_q <= S_START;
                end
                S_START: begin
                    if (ph_q == `SPF_OVS_MID) begin
                        ph_q <= 4'h0;
                        n_q  <= 4'h0;
                        st_q <= rxd ? S_IDLE : S_DATA;
                    end
                end
                S_DATA: begin
                    if (ph_q == `SPF_OVS_END) begin
                        sh_q <= {rxd, sh_q[7:1]};
                        n_q  <= n_q + 4'h1;
                        if (n_q == lastn) begin
                            st_q <= par_en ? S_PAR : S_STOP;
                            n_q  <= 4'h0;
                        end
                    end
                end
                S_PAR: begin
                    if (ph_q == `SPF_OVS_END) begin
                        pe_q <= (^dat) ^ rxd ^ par_odd ^ 1'b0;
                        n_q  <= 4'h0;
                        st_q <= S_STOP;
                    end
                end
                S_STOP: begin
                    if (ph_q == `SPF_OVS_END) begin
                        // resync: idle again right at mid stop bit
                        if (stop2 && n_q == 4'h0 && rxd) begin
                            n_q <= 4'h1;
                        end else begin
                            byte_v_q  <= 1'b1;
                            byte_q    <= dat;
                            par_err_q <= par_en & pe_q;
                            frm_err_q <= ~rxd;
                            st_q      <= S_IDLE;
                        end
                    end
                end
                default: st_q <= S_IDLE;
                endcase
            end
        end
    end
endmodule // spf_uart_rx

`default_nettype wire

// *** tb/spf_properties.sv ***
// Purpose: port-level checks for the serial port framer
// Assumes: register writes land at the APB access edge
// Notes:   control and source words are shadowed from observed writes
`default_nettype none
module spf_properties #(
    parameter PORT_IDX = 0
) (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        cts_n_q,
    input wire logic        line_diff,
    input wire logic        drv_en,
    input wire logic        net_tx_valid,
    input wire logic        net_tx_ready,
    input wire logic [7:0]  net_tx_data,
    input wire logic [15:0] net_tx_port,
    input wire logic        net_tx_bcast,
    input wire logic [31:0] net_tx_src,
    input wire logic        route_radio,
    input wire logic        net_rx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] ctrl_q;
    logic [31:0] eth_q, rad_q;
    logic        src_w_q, port_w_q;
    wire         wr = psel && penable && pwrite;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= 12'h006;
            src_w_q <= 1'b0;
            port_w_q <= 1'b0;
        end else if (wr) begin
            if (paddr == 8'h00) ctrl_q <= pwdata[11:0];
            if (paddr == 8'h0C) port_w_q <= 1'b1;
            if (paddr == 8'h10) eth_q <= pwdata;
            if (paddr == 8'h14) rad_q <= pwdata;
            if (paddr == 8'h14) src_w_q <= 1'b1;
        end
    end
    cts_flow_off_a: assert property (
        !ctrl_q[8] && !$past(ctrl_q[8]) |-> !cts_n_q) else $error("cts low");
    diff_port_a: assert property (
        $stable(ctrl_q) |-> line_diff == (PORT_IDX != 0 && ctrl_q[10]))
        else $error("line mode wrong");
    drv_p2p_a: assert property (!line_diff |-> drv_en)
        else $error("driver off");
    bcast_bridge_a: assert property (
        $stable(ctrl_q) |-> net_tx_bcast == ctrl_q[11]) else $error("bcast");
    src_iface_a: assert property (
        src_w_q && $past(src_w_q) |-> net_tx_src ==
        ($past(route_radio) ? $past(rad_q) : $past(eth_q))) else $error("src");
    port_dflt_a: assert property (
        !port_w_q && $past(rstn) |-> net_tx_port ==
        (PORT_IDX == 0 ? 16'h22B1 : 16'h22B2)) else $error("port number");
    discard_in_a: assert property (!ctrl_q[9] |-> net_rx_ready)
        else $error("no-protocol stall");
    frame_hold_a: assert property (
        net_tx_valid && !net_tx_ready |=> net_tx_valid && $stable(net_tx_data))
        else $error("frame byte dropped");
endmodule // spf_properties
bind spf_top spf_properties #(.PORT_IDX(PORT_IDX)) spf_properties_i (
    .clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .cts_n_q,
    .line_diff, .drv_en, .net_tx_valid, .net_tx_ready, .net_tx_data,
    .net_tx_port, .net_tx_bcast, .net_tx_src, .route_radio, .net_rx_ready);
`default_nettype wire

// *** tb/spf_term.sv ***
// Purpose: terminal equipment model driving the serial line
// Assumes: same rate and framing as the port, one stop bit
// Notes:   bad flips the parity bit to make a corrupt character
`default_nettype none
module spf_term #(
    parameter int BIT_CYC = 1085
) (
    input  wire logic clk_sys,
    input  wire logic cts_n,
    output var  logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rxd = 1'b1;
    task automatic send(input logic [7:0] b, input logic [1:0] par,
                        input logic bad);
        logic [10:0] f;
        logic        p;
        p = ^b ^ (par == 2'h1) ^ bad;
        f = (par == 2'h0) ? {3'h7, b, 1'b0} : {2'h3, p, b, 1'b0};
        while (cts_n) @(posedge clk_sys);
        for (int i = 0; i < ((par == 2'h0) ? 10 : 11); i++) begin
            rxd <= f[i];
            repeat (BIT_CYC) @(posedge clk_sys);
        end
    endtask
endmodule // spf_term
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the serial port framer
// Assumes: line runs at 115200 so characters stay short
// Notes:   frame bytes are logged as {last, data}
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, route_radio = 1'b0, net_tx_ready = 1'b1;
    logic [7:0]  paddr = 8'h00, net_tx_data;
    logic [31:0] pwdata = 32'h0, prdata, net_tx_src, r;
    logic        pready, pslverr, irq_q, rxd, txd, cts_n_q, line_diff, drv_en;
    logic        net_tx_valid, net_tx_last, net_tx_bcast, net_rx_ready, err;
    logic [15:0] net_tx_port;
    logic [8:0]  got[$];
    int          n_mismatch = 0, checks_done = 0, cyc = 0;
    spf_top spf_top_i (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .irq_q, .rxd, .txd,
        .rts_n(1'b0), .cts_n_q, .line_diff, .drv_en, .net_tx_valid,
        .net_tx_ready, .net_tx_data, .net_tx_last, .net_tx_port,
        .net_tx_bcast, .net_tx_src, .route_radio, .net_rx_valid(1'b0),
        .net_rx_ready(), .net_rx_data(8'h00), .net_rx_last(1'b0));
    spf_term term_i (.clk_sys, .cts_n(cts_n_q), .rxd);
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (net_tx_valid && net_tx_ready) got.push_back({net_tx_last,
            net_tx_data});
        if (cyc == 90000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        checks_done++;
        if (a !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    task automatic t_regs;
        rd(8'h00, 32'h006);
        rd(8'h04, 32'h005);
        rd(8'h08, 32'h640);
        rd(8'h0C, 32'h22B1);
        apb(1'b1, 8'h04, 32'hBB8);
        rd(8'h04, 32'h7D0);
        apb(1'b1, 8'h08, 32'h0);
        rd(8'h08, 32'h001);
        rd(8'h40, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, 8'h10, 32'h0A000001);
        apb(1'b1, 8'h14, 32'h0A000002);
        route_radio <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(net_tx_src, 32'h0A000002);
    endtask
    task automatic t_discard;
        apb(1'b1, 8'h00, 32'h009);
        term_i.send(8'h3C, 2'h0, 1'b0);
        repeat (200) @(posedge clk_sys);
        chk(got.size(), 0);
        rd(8'h1C, 32'h0);
    endtask
    task automatic t_idle;
        apb(1'b1, 8'h00, 32'h209);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'h640);
        apb(1'b1, 8'h20, 32'h1);
        term_i.send(8'h5A, 2'h0, 1'b0);
        wait (got.size() >= 1);
        chk(got[0], 9'h15A);
        rd(8'h1C, 32'h1);
        chk(irq_q, 1'b1);
        apb(1'b1, 8'h24, 32'h3F);
        repeat (3) @(posedge clk_sys);
        chk(irq_q, 1'b0);
    endtask
    task automatic t_size;
        apb(1'b1, 8'h08, 32'h2);
        apb(1'b1, 8'h04, 32'h5);
        net_tx_ready <= 1'b0;
        term_i.send(8'hA1, 2'h0, 1'b0);
        term_i.send(8'hB2, 2'h0, 1'b0);
        repeat (100) @(posedge clk_sys);
        net_tx_ready <= 1'b1;
        wait (got.size() >= 3);
        chk(got[1], 9'h0A1);
        chk(got[2], 9'h1B2);
        apb(1'b0, 8'h1C, 32'h0);
        chk(r[1], 1'b1);
    endtask
    task automatic t_parity;
        apb(1'b1, 8'h00, 32'h249);
        term_i.send(8'hC3, 2'h2, 1'b1);
        repeat (200) @(posedge clk_sys);
        apb(1'b0, 8'h1C, 32'h0);
        chk(r[2], 1'b1);
        chk(got.size(), 3);
        chk(irq_q, 1'b0);
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        t_regs();
        t_discard();
        t_idle();
        t_size();
        t_parity();
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
